//--- hw/ctm_defs.svh
/*
  Register offsets, field positions, reset values and bus codes of the
  counter-timer control block.
  Assumes byte addresses on a 32-bit AXI4-Lite register bus.
*/
`ifndef CTM_DEFS_SVH
`define CTM_DEFS_SVH
`define CTM_OFS_CTRL    8'h00
`define CTM_OFS_CLKSEL  8'h04
`define CTM_OFS_RELOAD  8'h08
`define CTM_OFS_COUNT   8'h0C
`define CTM_OFS_STAT    8'h10
`define CTM_OFS_MASK    8'h14
`define CTM_B_CLKREQ    12
`define CTM_B_SLEEP     11
`define CTM_B_OPOL      10
`define CTM_B_PD        9
`define CTM_B_BYP       8
`define CTM_B_RLD       7
`define CTM_B_OEN       6
`define CTM_B_DIR       5
`define CTM_B_IPOL      4
`define CTM_B_MODE_HI   3
`define CTM_B_MODE_LO   2
`define CTM_B_RST       1
`define CTM_B_EN        0
`define CTM_PD_RST      1'b1
`define CTM_RELOAD_RST  16'hFFFF
`define CTM_CNT_MAX     16'hFFFF
`define CTM_CNT_ZERO    16'h0000
`define CTM_TIMER_CLOCK_SELECT_RST    4'h0
`define CTM_RESP_OKAY   2'h0
`define CTM_RESP_SLVERR 2'h2
`define CTM_FILT_LEN    4
`endif

//--- hw/ctm_pkg.sv
/*
  Types and the byte-merge helper of the counter-timer control block.
  Assumes a 32-bit register bus with four byte strobes.
*/
package ctm_pkg;
  typedef enum logic [1:0] {CTM_TIMER, CTM_EVENT, CTM_ONESHOT,
                            CTM_MEASURE} ctm_mode_e;
  typedef logic [1:0]  ctm_resp_t;
  typedef logic [31:0] ctm_word_t;

  function automatic ctm_word_t ctm_merge(input ctm_word_t old_v,
                                          input ctm_word_t new_v,
                                          input logic [3:0] strb);
    ctm_word_t r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

//--- hw/ctm_in_filter.sv
/*
  Input pin synchroniser and noise filter with bypass.
  Assumes the pin is asynchronous to clk_i; the filtered level must stay
  stable for FILT_LEN cycles before it is passed on.
*/
`timescale 1ns/10ps
`include "ctm_defs.svh"
module ctm_in_filter #(
  parameter int unsigned FILT_LEN = `CTM_FILT_LEN
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and control
  input  wire logic pin_i,
  input  wire logic bypass_i,
  // Result
  output logic      level_o
);
  logic       s1_q;
  logic       s2_q;
  logic       stable_q;
  logic       level_q;
  logic [3:0] cnt_q;
  wire        differs = s2_q != stable_q;
  wire        settled = cnt_q == 4'(FILT_LEN - 1);

  always_ff @(posedge clk_i)
  begin
    s1_q <= pin_i;
    s2_q <= s1_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q    <= '0;
      stable_q <= 1'b0;
      level_q  <= 1'b0;
    end
    else
    begin
      cnt_q    <= (differs && !settled) ? cnt_q + 4'h1 : '0;
      stable_q <= (differs && settled) ? s2_q : stable_q;
      level_q  <= bypass_i ? s2_q : stable_q;
    end
  end

  assign level_o = level_q;
endmodule // ctm_in_filter

//--- hw/ctm_counter_timer_control.sv
/*
  Control register and control behaviour of a 16-bit counter-timer,
  reached over AXI4-Lite, with input filter, output pin and interrupt.
  Assumes one AXI4-Lite master with at most one write and one read
  under way; the input pin is asynchronous.
// Contract
// - Control bit 12 reads back the main clock need output.
// - Control bit 11 reads the synchronised sleep permit input.
// - Control bit 10 sets output pin polarity, 1 active low.
// - Control bit 9 powers the timer down and resets to 1.
// - Control bit 8 bypasses the input noise filter.
// - Bit 7 picks reload or wrap on overflow in timer and event mode.
// - Control bit 6 enables the output pin, else it stays inactive.
// - In event mode the direction bit picks up or down counting.
// - In timer mode the direction bit lets an idle input pause counts.
// - The input polarity bit makes the input active low when 1.
// - The two-bit mode field selects timer, event, one-shot, measure.
// - Writing the reset bit stops, loads reload and clears enable.
// - Reset completes within two to the clock select plus one ticks.
// - Interrupt events are held off while reset or disabled.
// - Enable starts and stops counting and idles the pulse output.
// - Enable clears itself at one-shot end and at reset completion.
*/
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "ctm_defs.svh"
module ctm_counter_timer_control #(
  parameter int unsigned ADDR_W   = 8,
  parameter int unsigned FILT_LEN = `CTM_FILT_LEN
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output ctm_pkg::ctm_resp_t     bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output ctm_pkg::ctm_word_t     rdata_o,
  output ctm_pkg::ctm_resp_t     rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  // Pins and system
  input  wire logic              timer_input_pin_i,
  output logic                   timer_output_pin_o,
  input  wire logic              sleep_permit_i,
  output logic                   main_clock_need_flag_o,
  output logic                   irq_o
);
  import ctm_pkg::*;

  // Bus state
  logic              aw_have_q;
  logic [7:0]        awaddr_q;
  logic              w_have_q;
  ctm_word_t         wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  ctm_resp_t         bresp_q;
  logic              rvalid_q;
  ctm_word_t         rdata_q;
  ctm_resp_t         rresp_q;
  logic              rd_ctrl_q;
  // Control fields
  logic              output_pin_polarity_q;
  logic              powered_off_flag_q;
  logic              filter_bypass_q;
  logic              reload_on_wrap_q;
  logic              output_pin_function_on_q;
  logic              count_direction_or_gate_q;
  logic              input_pin_polarity_q;
  ctm_mode_e         mode_q;
  logic              rst_pend_q;
  logic              en_q;
  logic              main_clock_need_flag_q;
  logic [3:0]        timer_clock_select_q;
  // Timer state
  logic [15:0]       reload_q;
  logic [15:0]       count_q;
  logic [15:0]       presc_q;
  logic              armed_q;
  logic              in_act_q;
  logic              en_prev_q;
  logic              out_act_q;
  logic              pin_q;
  logic              stat_q;
  logic              mask_q;
  logic              sl1_q;
  logic              sl2_q;
  logic              filt_lvl;
  // Next values
  logic [15:0]       cnt_d;
  logic [15:0]       rel_d;
  logic              armed_d;
  logic              ev_d;
  logic              en_clr_d;
  logic              tog_d;

  function automatic logic all_ones(input logic [15:0] v,
                                    input logic [4:0]  n);
    logic [16:0] m;
    m = (17'h0_0001 << n) - 17'h0_0001;
    return &(v | ~m[15:0]);
  endfunction

  function automatic logic [15:0] step(input logic [15:0] v,
                                       input logic        up);
    return up ? v + 16'h0001 : v - 16'h0001;
  endfunction

  function automatic logic [15:0] wrap_val(input logic        rld,
                                           input logic [15:0] rel,
                                           input logic        up);
    return rld ? rel : (up ? `CTM_CNT_ZERO : `CTM_CNT_MAX);
  endfunction

  ctm_in_filter #(
    .FILT_LEN (FILT_LEN)
  ) u_filter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .pin_i    (timer_input_pin_i),
    .bypass_i (filter_bypass_q),
    .level_o  (filt_lvl)
  );

  // Write decode; the write fires once address and data are both held
  wire       do_wr    = aw_have_q && w_have_q && !bvalid_q;
  wire       wr_ctrl  = do_wr && awaddr_q == `CTM_OFS_CTRL;
  wire       wr_csel  = do_wr && awaddr_q == `CTM_OFS_CLKSEL;
  wire       wr_rel   = do_wr && awaddr_q == `CTM_OFS_RELOAD;
  wire       wr_stat  = do_wr && awaddr_q == `CTM_OFS_STAT;
  wire       wr_mask  = do_wr && awaddr_q == `CTM_OFS_MASK;
  wire       wr_cnt   = do_wr && awaddr_q == `CTM_OFS_COUNT;
  wire       wr_hit   = wr_ctrl || wr_csel || wr_rel || wr_stat ||
                        wr_mask || wr_cnt;
  wire       ar_take  = arvalid_i && !rvalid_q;
  wire [7:0] ra       = 8'(araddr_i);

  wire ctm_word_t ctrl_word = {19'h0_0000, main_clock_need_flag_q,
                               sl2_q, output_pin_polarity_q,
                               powered_off_flag_q, filter_bypass_q,
                               reload_on_wrap_q, output_pin_function_on_q,
                               count_direction_or_gate_q,
                               input_pin_polarity_q, mode_q, rst_pend_q,
                               en_q};
  wire ctm_word_t nw_ctrl = ctm_merge(ctrl_word, wdata_q, wstrb_q);
  wire ctm_word_t nw_csel = ctm_merge({28'h000_0000,
                                       timer_clock_select_q},
                                      wdata_q, wstrb_q);
  wire ctm_word_t nw_rel  = ctm_merge({16'h0000, reload_q},
                                      wdata_q, wstrb_q);
  wire ctm_word_t w1c     = wdata_q & {32{wstrb_q[0]}};

  wire       rd_hit  = ra == `CTM_OFS_CTRL   || ra == `CTM_OFS_CLKSEL ||
                       ra == `CTM_OFS_RELOAD || ra == `CTM_OFS_COUNT  ||
                       ra == `CTM_OFS_STAT   || ra == `CTM_OFS_MASK;
  wire ctm_word_t rd_mux =
    (ra == `CTM_OFS_CTRL)   ? ctrl_word :
    (ra == `CTM_OFS_CLKSEL) ? {28'h000_0000, timer_clock_select_q} :
    (ra == `CTM_OFS_RELOAD) ? {16'h0000, reload_q} :
    (ra == `CTM_OFS_COUNT)  ? {16'h0000, count_q} :
    (ra == `CTM_OFS_STAT)   ? {31'h0000_0000, stat_q} :
    (ra == `CTM_OFS_MASK)   ? {31'h0000_0000, mask_q} : '0;

  // Timer decode
  wire in_act  = filt_lvl ^ input_pin_polarity_q;
  wire in_edge = in_act && !in_act_q;
  wire tick    = !powered_off_flag_q &&
                 all_ones(presc_q, {1'b0, timer_clock_select_q});
  // Completion waits until the low clock select plus one prescaler bits are all ones, hence a variable wait
  wire rst_done = rst_pend_q && !powered_off_flag_q &&
                  all_ones(presc_q, 5'(timer_clock_select_q) + 5'h01);
  wire run     = en_q && !rst_pend_q && !powered_off_flag_q;
  wire up      = count_direction_or_gate_q;
  wire gate_ok = !count_direction_or_gate_q || in_act;

  always_comb
  begin
    cnt_d    = count_q;
    rel_d    = wr_rel && mode_q != CTM_MEASURE ? nw_rel[15:0] : reload_q;
    armed_d  = armed_q && en_q;
    ev_d     = 1'b0;
    en_clr_d = 1'b0;
    tog_d    = 1'b0;
    if (rst_done)
    begin
      cnt_d    = reload_q;
      armed_d  = 1'b0;
      en_clr_d = 1'b1;
    end
    else if (run)
    begin
      unique case (mode_q)
        CTM_TIMER:
          if (tick && gate_ok)
          begin
            ev_d  = count_q == `CTM_CNT_ZERO;
            tog_d = ev_d;
            cnt_d = ev_d ? wrap_val(reload_on_wrap_q, reload_q, 1'b0)
                         : step(count_q, 1'b0);
          end
        CTM_EVENT:
          if (in_edge)
          begin
            ev_d  = count_q == (up ? `CTM_CNT_MAX : `CTM_CNT_ZERO);
            tog_d = ev_d;
            cnt_d = ev_d ? wrap_val(reload_on_wrap_q, reload_q, up)
                         : step(count_q, up);
          end
        CTM_ONESHOT:
          if (tick)
          begin
            ev_d     = count_q == `CTM_CNT_ZERO;
            en_clr_d = ev_d;
            cnt_d    = ev_d ? reload_q : step(count_q, 1'b0);
          end
        CTM_MEASURE:
          if (in_edge)
          begin
            cnt_d = `CTM_CNT_ZERO;
            armed_d = 1'b1;
            ev_d  = armed_q;
            rel_d = armed_q ? count_q : rel_d;
          end
          else if (tick)
          begin
            ev_d     = count_q == `CTM_CNT_MAX;
            en_clr_d = ev_d;
            rel_d    = ev_d ? `CTM_CNT_ZERO : rel_d;
            cnt_d    = ev_d ? count_q : step(count_q, 1'b1);
          end
      endcase
    end
  end

  // Pulse output: a change of enable always returns it to idle
  wire en_chg = en_q != en_prev_q;
  wire out_d  = en_chg ? 1'b0 :
                (mode_q == CTM_ONESHOT) ? run && !en_clr_d :
                (mode_q == CTM_MEASURE) ? 1'b0 : out_act_q ^ tog_d;
  wire pin_d  = (output_pin_function_on_q && out_act_q) ^
                output_pin_polarity_q;
  wire need_d = !powered_off_flag_q && (en_q || rst_pend_q);

  always_ff @(posedge clk_i)
  begin
    sl1_q <= sleep_permit_i;
    sl2_q <= sl1_q;
  end

  // Bus handshake
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
    end
    else
    begin
      aw_have_q <= do_wr ? 1'b0 : aw_have_q || (awvalid_i && awready_o);
      w_have_q  <= do_wr ? 1'b0 : w_have_q || (wvalid_i && wready_o);
      bvalid_q  <= do_wr || (bvalid_q && !bready_i);
      rvalid_q  <= ar_take || (rvalid_q && !rready_i);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bresp_q   <= `CTM_RESP_OKAY;
      rdata_q   <= '0;
      rresp_q   <= `CTM_RESP_OKAY;
      rd_ctrl_q <= 1'b0;
    end
    else
    begin
      awaddr_q  <= awvalid_i && awready_o ? 8'(awaddr_i) : awaddr_q;
      wdata_q   <= wvalid_i && wready_o ? wdata_i : wdata_q;
      wstrb_q   <= wvalid_i && wready_o ? wstrb_i : wstrb_q;
      bresp_q   <= !do_wr ? bresp_q :
                   wr_hit ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
      rdata_q   <= ar_take ? rd_mux : rdata_q;
      rresp_q   <= !ar_take ? rresp_q :
                   rd_hit ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
      rd_ctrl_q <= ar_take ? ra == `CTM_OFS_CTRL : rd_ctrl_q;
    end
  end

  // Control register; hardware clearing of enable wins over a write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      output_pin_polarity_q     <= 1'b0;
      powered_off_flag_q        <= `CTM_PD_RST;
      filter_bypass_q           <= 1'b0;
      reload_on_wrap_q          <= 1'b0;
      output_pin_function_on_q  <= 1'b0;
      count_direction_or_gate_q <= 1'b0;
      input_pin_polarity_q      <= 1'b0;
      mode_q                    <= CTM_TIMER;
      timer_clock_select_q      <= `CTM_TIMER_CLOCK_SELECT_RST;
    end
    else if (wr_ctrl)
    begin
      output_pin_polarity_q     <= nw_ctrl[`CTM_B_OPOL];
      powered_off_flag_q        <= nw_ctrl[`CTM_B_PD];
      filter_bypass_q           <= nw_ctrl[`CTM_B_BYP];
      reload_on_wrap_q          <= nw_ctrl[`CTM_B_RLD];
      output_pin_function_on_q  <= nw_ctrl[`CTM_B_OEN];
      count_direction_or_gate_q <= nw_ctrl[`CTM_B_DIR];
      input_pin_polarity_q      <= nw_ctrl[`CTM_B_IPOL];
      mode_q <= ctm_mode_e'(nw_ctrl[`CTM_B_MODE_HI:`CTM_B_MODE_LO]);
    end
    else if (wr_csel)
    begin
      timer_clock_select_q <= nw_csel[3:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_pend_q <= 1'b0;
      en_q       <= 1'b0;
    end
    else
    begin
      rst_pend_q <= (wr_ctrl && nw_ctrl[`CTM_B_RST]) ||
                    (rst_pend_q && !rst_done);
      en_q       <= en_clr_d ? 1'b0 :
                    wr_ctrl ? nw_ctrl[`CTM_B_EN] : en_q;
    end
  end

  // Timer core and interrupt; a new event wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reload_q  <= `CTM_RELOAD_RST;
      count_q   <= `CTM_CNT_MAX;
      presc_q   <= '0;
      armed_q   <= 1'b0;
      in_act_q  <= 1'b0;
      en_prev_q <= 1'b0;
      out_act_q <= 1'b0;
      pin_q     <= 1'b0;
      stat_q    <= 1'b0;
      mask_q    <= 1'b0;
      main_clock_need_flag_q <= 1'b0;
    end
    else
    begin
      reload_q  <= rel_d;
      count_q   <= cnt_d;
      presc_q   <= powered_off_flag_q ? presc_q : presc_q + 16'h0001;
      armed_q   <= armed_d;
      in_act_q  <= in_act;
      en_prev_q <= en_q;
      out_act_q <= out_d;
      pin_q     <= pin_d;
      stat_q    <= ev_d || (stat_q && !(wr_stat && w1c[0]));
      mask_q    <= wr_mask ? wdata_q[0] : mask_q;
      main_clock_need_flag_q <= need_d;
    end
  end

  assign awready_o              = !aw_have_q && !bvalid_q;
  assign wready_o               = !w_have_q && !bvalid_q;
  assign bvalid_o               = bvalid_q;
  assign bresp_o                = bresp_q;
  assign arready_o              = !rvalid_q;
  assign rvalid_o               = rvalid_q;
  assign rdata_o                = rdata_q;
  assign rresp_o                = rresp_q;
  assign timer_output_pin_o     = pin_q;
  assign main_clock_need_flag_o = main_clock_need_flag_q;
  assign irq_o                  = stat_q && mask_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pd_no_need;
    powered_off_flag_q ##1 powered_off_flag_q |-> !main_clock_need_flag_o;
  endproperty
  a_pd_no_need: assert property (p_pd_no_need)
    else $error("clock need high while powered down");

  property p_pd_frozen;
    powered_off_flag_q && mode_q == CTM_TIMER |=> $stable(count_q);
  endproperty
  a_pd_frozen: assert property (p_pd_frozen)
    else $error("count moved while powered down");

  property p_rst_done;
    rst_pend_q && !powered_off_flag_q && !wr_ctrl && !wr_csel &&
    timer_clock_select_q == 4'h0 |-> ##[1:2] !rst_pend_q;
  endproperty
  a_rst_done: assert property (p_rst_done)
    else $error("reset did not complete in time");

  property p_rst_load;
    $fell(rst_pend_q) |-> !en_q && count_q == $past(reload_q);
  endproperty
  a_rst_load: assert property (p_rst_load)
    else $error("reset completion did not load and disable");

  property p_os_end;
    run && mode_q == CTM_ONESHOT && tick && count_q == `CTM_CNT_ZERO
    |=> !en_q ##1 !out_act_q;
  endproperty
  a_os_end: assert property (p_os_end)
    else $error("one-shot end did not clear enable");

  property p_wrap_down;
    run && mode_q == CTM_TIMER && tick && gate_ok && !reload_on_wrap_q &&
    count_q == `CTM_CNT_ZERO |=> count_q == `CTM_CNT_MAX;
  endproperty
  a_wrap_down: assert property (p_wrap_down)
    else $error("timer underflow did not wrap");

  property p_gate;
    run && mode_q == CTM_TIMER && count_direction_or_gate_q && !in_act
    |=> count_q == $past(count_q);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated timer counted");

  property p_pin_idle;
    !output_pin_function_on_q |=> pin_q == $past(output_pin_polarity_q);
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("output pin not idle while disabled");

  property p_reserved;
    rvalid_q && rd_ctrl_q |-> rdata_q[31:13] == 19'h0_0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits read non-zero");

  property p_no_ev_idle;
    !en_q && !stat_q ##1 !en_q |-> !stat_q;
  endproperty
  a_no_ev_idle: assert property (p_no_ev_idle)
    else $error("event raised while disabled");

  c_os_done: cover property ($fell(en_q) && mode_q == CTM_ONESHOT);
  c_measure: cover property (run && mode_q == CTM_MEASURE && ev_d);
  c_reset:   cover property ($fell(rst_pend_q));
  c_irq:     cover property ($rose(irq_o));
endmodule // ctm_counter_timer_control

//--- test/ctm_pin_model.sv
/* Far-side pin model: drives the timer input pin, counts output changes.
   Assumes one clock; pin changes land just after a rising edge. */
`timescale 1ns/10ps
module ctm_pin_model (
  // Clock
  input  wire logic clk_i,
  // Pins
  input  wire logic out_pin_i,
  output logic      in_pin_o
);
  int   toggles;
  logic last_q;
  initial
  begin
    in_pin_o = 1'b0;
    toggles  = 0;
    last_q   = 1'b0;
  end
  always @(posedge clk_i)
  begin
    if (out_pin_i !== last_q)
      toggles <= toggles + 1;
    last_q <= out_pin_i;
  end
  // Hold lv for w cycles, then return; quiet gap lets the filter settle
  task automatic pulse(input logic lv, input int w);
    @(posedge clk_i);
    in_pin_o <= lv;
    repeat (w) @(posedge clk_i);
    in_pin_o <= ~lv;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // ctm_pin_model

//--- test/ctm_counter_timer_control_tb_top.sv
/* Testbench of the counter-timer control block over AXI4-Lite.
   Assumes a 20 MHz clock and a filter length of 4. */
`timescale 1ns/10ps
`include "ctm_defs.svh"
module ctm_counter_timer_control_tb_top;
  import ctm_pkg::*;
  logic       clk_i, rst_i, awvalid_i, wvalid_i, bready_i, arvalid_i;
  logic       rready_i, awready_o, wready_o, bvalid_o, arready_o;
  logic       rvalid_o, slp, tin, tout, clk_need, irq_o;
  logic [7:0] awaddr_i, araddr_i;
  logic [3:0] wstrb_i;
  ctm_resp_t  bresp_o, rresp_o, rr;
  ctm_word_t  wdata_i, rdata_o, v, u;
  int         bad_count, samples_checked, t0, n;

  ctm_counter_timer_control #(.ADDR_W(8), .FILT_LEN(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
    .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
    .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
    .rready_i(rready_i), .timer_input_pin_i(tin),
    .timer_output_pin_o(tout), .sleep_permit_i(slp),
    .main_clock_need_flag_o(clk_need), .irq_o(irq_o));
  ctm_pin_model pins (.clk_i(clk_i), .out_pin_i(tout), .in_pin_o(tin));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr_i  <= a;
    wdata_i   <= d;
    awvalid_i <= 1'b1;
    wvalid_i  <= 1'b1;
    bready_i  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready_o)
        awvalid_i <= 1'b0;
      if (wready_o)
        wvalid_i <= 1'b0;
    end
    while (!bvalid_o);
    rr = bresp_o;
  endtask
  task automatic rd(input logic [7:0] a, output ctm_word_t d);
    araddr_i  <= a;
    arvalid_i <= 1'b1;
    rready_i  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready_o)
        arvalid_i <= 1'b0;
    end
    while (!rvalid_o);
    d  = rdata_o;
    rr = rresp_o;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // Poll the self-clearing reset bit, as software must
  task automatic settle();
    n = 0;
    do
    begin
      rd(`CTM_OFS_CTRL, v);
      n++;
    end
    while (v[`CTM_B_RST] && n < 8);
    chk(32'(n <= 2), 32'h1);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    #(50 * 20000);
    bad_count++;
    stop_test();
  end
  initial
  begin
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    awaddr_i = '0;
    araddr_i = '0;
    wdata_i = '0;
    wstrb_i = 4'hF;
    slp = 1'b1;
    rst_i = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rc(`CTM_OFS_CTRL, 32'hA00);
    rc(`CTM_OFS_COUNT, 32'hFFFF);
    rd(8'h18, v);
    chk(32'(rr), 32'h2);
    wr(8'h18, 32'h0);
    chk(32'(rr), 32'h2);
    wr(`CTM_OFS_CTRL, 32'hFFFF_E000);
    chk(32'(rr), 32'h0);
    rc(`CTM_OFS_CTRL, 32'h800);
    slp <= 1'b0;
    repeat (4) @(posedge clk_i);
    rc(`CTM_OFS_CTRL, 32'h0);
    slp <= 1'b1;
    wr(`CTM_OFS_CTRL, 32'h400);
    repeat (2) @(posedge clk_i);
    chk(32'(tout), 32'h1);
    wr(`CTM_OFS_RELOAD, 32'h3);
    wr(`CTM_OFS_MASK, 32'h1);
    wr(`CTM_OFS_CTRL, 32'h0C3);
    settle();
    rc(`CTM_OFS_COUNT, 32'h3);
    rc(`CTM_OFS_CTRL, 32'h8C0);
    t0 = pins.toggles;
    wr(`CTM_OFS_CTRL, 32'h0C1);
    repeat (2) @(posedge clk_i);
    chk(32'(clk_need), 32'h1);
    rc(`CTM_OFS_CTRL, 32'h18C1);
    repeat (20) @(posedge clk_i);
    chk(32'(irq_o), 32'h1);
    rd(`CTM_OFS_COUNT, v);
    chk(32'(v > 3), 32'h0);
    chk(32'(pins.toggles > t0), 32'h1);
    // Without reload the count rolls over to the top
    wr(`CTM_OFS_CTRL, 32'h041);
    repeat (10) @(posedge clk_i);
    rd(`CTM_OFS_COUNT, v);
    chk(32'(v[15:8]), 32'hFF);
    wr(`CTM_OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(32'(clk_need), 32'h0);
    wr(`CTM_OFS_STAT, 32'h1);
    rc(`CTM_OFS_STAT, 32'h0);
    chk(32'(irq_o), 32'h0);
    wr(`CTM_OFS_RELOAD, 32'h40);
    wr(`CTM_OFS_CTRL, 32'h04A);
    settle();
    wr(`CTM_OFS_CTRL, 32'h449);
    // Pulse starts one cycle after the enable change has passed
    repeat (3) @(posedge clk_i);
    chk(32'(tout), 32'h0);
    wr(`CTM_OFS_CTRL, 32'h448);
    repeat (2) @(posedge clk_i);
    chk(32'(tout), 32'h1);
    rd(`CTM_OFS_COUNT, u);
    repeat (5) @(posedge clk_i);
    rc(`CTM_OFS_COUNT, u);
    wr(`CTM_OFS_CTRL, 32'h049);
    repeat (80) @(posedge clk_i);
    rc(`CTM_OFS_CTRL, 32'h848);
    wr(`CTM_OFS_RELOAD, 32'h10);
    wr(`CTM_OFS_CTRL, 32'h1A6);
    settle();
    wr(`CTM_OFS_CTRL, 32'h1A5);
    pins.pulse(1'b1, 6);
    pins.pulse(1'b1, 6);
    rc(`CTM_OFS_COUNT, 32'h12);
    wr(`CTM_OFS_CTRL, 32'h1B5);
    repeat (4) @(posedge clk_i);
    rc(`CTM_OFS_COUNT, 32'h13);
    wr(`CTM_OFS_CTRL, 32'h0B5);
    pins.pulse(1'b1, 2);
    rc(`CTM_OFS_COUNT, 32'h13);
    wr(`CTM_OFS_CTRL, 32'h195);
    pins.pulse(1'b1, 2);
    rc(`CTM_OFS_COUNT, 32'h12);
    wr(`CTM_OFS_CTRL, 32'h021);
    repeat (6) @(posedge clk_i);
    rc(`CTM_OFS_COUNT, 32'h12);
    wr(`CTM_OFS_CTRL, 32'h00C);
    wr(`CTM_OFS_RELOAD, 32'h55);
    rc(`CTM_OFS_RELOAD, 32'h10);
    // Edges 15 clocks apart; count restarts at zero after the first
    wr(`CTM_OFS_CTRL, 32'h10D);
    pins.pulse(1'b1, 6);
    pins.pulse(1'b1, 6);
    rc(`CTM_OFS_RELOAD, 32'hE);
    stop_test();
  end
endmodule // ctm_counter_timer_control_tb_top
